// ### logic/sfsup_top.sv
// supply fault supervisor: deglitch, output gating, latched flags, auto restart
// assumes condition inputs are asynchronous comparator levels; requests are core_clk logic
`timescale 1ns/1ps
module sfsup_top #(
  parameter int unsigned RESTART_CYC = sfsup_pkg::RESTART_CYC,
  parameter int unsigned SUPPLY_FILT_CYC = sfsup_pkg::SUPPLY_FILT_CYC,
  parameter int unsigned PUMP_FILT_CYC = sfsup_pkg::PUMP_FILT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // analog conditions
  input wire sfsup_pkg::sfsup_cond_t cond_raw,
  input wire logic pump_settled,
  // controller side
  input wire logic fail_mode,
  input wire logic [sfsup_pkg::NUM_OUT-1:0] on_write,
  input wire logic [sfsup_pkg::NUM_OUT-1:0] off_write,
  input wire logic dev_status_read,
  input wire logic quick_status_read,
  // outputs
  output logic [sfsup_pkg::NUM_OUT-1:0] power_outputs,
  output logic [sfsup_pkg::NUM_OUT-1:0] inrush_current_window,
  output sfsup_pkg::sfsup_flags_t flags
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_UP, ST_RUN, ST_SHUT} sfsup_state_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [sfsup_pkg::FILT_W-1:0] uv_cnt;
    logic [sfsup_pkg::FILT_W-1:0] ov_cnt;
    logic [sfsup_pkg::FILT_W-1:0] cp_cnt;
    logic uv_f;
    logic ov_f;
    logic cp_f;
    sfsup_state_t st;
    logic [sfsup_pkg::RST_W-1:0] rs_cnt;
    logic [sfsup_pkg::NUM_OUT-1:0] want;
    logic [sfsup_pkg::NUM_OUT-1:0] outs;
    logic [sfsup_pkg::NUM_OUT-1:0] inrush;
    sfsup_pkg::sfsup_flags_t flg;
  } sfsup_regs_t;

  sfsup_regs_t s_reg;
  sfsup_regs_t s_next;

  // saturating deglitch step; restarts at zero on any gap
  function automatic logic [sfsup_pkg::FILT_W-1:0] filt_step(
    input logic lvl,
    input logic [sfsup_pkg::FILT_W-1:0] cnt,
    input int unsigned lim
  );
    if (!lvl)
      return '0;
    if (cnt >= sfsup_pkg::FILT_W'(lim))
      return cnt;
    return cnt + 11'h001;
  endfunction

  logic uv_s;
  logic ov_s;
  logic cp_s;
  logic settled_s;
  assign uv_s = s_reg.sync2[0];
  assign ov_s = s_reg.sync2[1];
  assign cp_s = s_reg.sync2[2];
  assign settled_s = s_reg.sync2[3];

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = {pump_settled, cond_raw.pump_bad, cond_raw.supply_high,
      cond_raw.supply_low};
    s_next.sync2 = s_reg.sync1;
    s_next.uv_cnt = filt_step(uv_s, s_reg.uv_cnt, SUPPLY_FILT_CYC);
    s_next.ov_cnt = filt_step(ov_s, s_reg.ov_cnt, SUPPLY_FILT_CYC);
    s_next.cp_cnt = filt_step(cp_s, s_reg.cp_cnt, PUMP_FILT_CYC);
    s_next.uv_f = uv_s && (s_reg.uv_cnt >= sfsup_pkg::FILT_W'(SUPPLY_FILT_CYC - 1));
    s_next.ov_f = ov_s && (s_reg.ov_cnt >= sfsup_pkg::FILT_W'(SUPPLY_FILT_CYC - 1));
    s_next.cp_f = cp_s && (s_reg.cp_cnt >= sfsup_pkg::FILT_W'(PUMP_FILT_CYC - 1));
    s_next.inrush = '0;
    // commanded state is remembered while outputs are blocked, except that normal mode clears it on filtered undervoltage and in ST_SHUT
    s_next.want = (s_reg.want & ~off_write) | on_write;
    // flags: set wins over read-clear; active fault never cleared
    s_next.flg.supply_low_flag = s_reg.uv_f ||
      (s_reg.flg.supply_low_flag && !(dev_status_read && !uv_s));
    s_next.flg.supply_high_flag = s_reg.ov_f ||
      (s_reg.flg.supply_high_flag && !(dev_status_read && !ov_s));
    s_next.flg.pump_fault_flag = s_reg.cp_f ||
      (s_reg.flg.pump_fault_flag && !(quick_status_read && !cp_s));
    s_next.flg.device_fault_summary_flag = s_next.flg.supply_low_flag ||
      s_next.flg.supply_high_flag || s_next.flg.pump_fault_flag;
    case (s_reg.st)
      ST_UP:
      begin
        s_next.outs = '0;
        if (s_reg.uv_f)
        begin
          // undervoltage during power-up must not let outputs start on settling
          if (!fail_mode)
            s_next.want = '0;
          s_next.rs_cnt = '0;
          s_next.st = ST_SHUT;
        end
        else if (settled_s && !s_reg.cp_f)
        begin
          s_next.st = ST_RUN;
          s_next.outs = s_next.want;
          s_next.inrush = s_next.want;
        end
      end
      ST_RUN:
      begin
        if (s_reg.uv_f)
        begin
          s_next.outs = '0;
          // fail mode keeps the channels for the automatic restart
          if (!fail_mode)
            s_next.want = '0;
          s_next.rs_cnt = '0;
          s_next.st = ST_SHUT;
        end
        else if (s_reg.cp_f)
        begin
          s_next.outs = '0;
          s_next.st = ST_UP;
        end
        else
        begin
          s_next.outs = s_next.want;
          s_next.inrush = s_next.want & ~s_reg.outs;
        end
      end
      ST_SHUT:
      begin
        s_next.outs = '0;
        if (fail_mode)
        begin
          // pre-fault channels and new commands both wait for the timer
          if (uv_s)
            s_next.rs_cnt = '0;
          else if (s_reg.rs_cnt >= sfsup_pkg::RST_W'(RESTART_CYC - 1))
          begin
            s_next.st = ST_UP;
            s_next.rs_cnt = '0;
          end
          else
            s_next.rs_cnt = s_reg.rs_cnt + 25'h0000001;
        end
        else if (!uv_s && !s_reg.uv_f && |on_write)
          s_next.st = ST_UP;
        else
          s_next.want = '0;
      end
      default:
        s_next.st = ST_UP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.st <= ST_UP;
    end
    else
      s_reg <= s_next;
  end

  assign power_outputs = s_reg.outs;
  assign inrush_current_window = s_reg.inrush;
  assign flags = s_reg.flg;

  ////////////////////////////////////////////////////////////////////////////
  property p_uv_off;
    @(posedge core_clk) disable iff (sys_rst) s_reg.uv_f |=> (power_outputs == 5'h00);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("outputs on after undervoltage");

  property p_uv_flag;
    @(posedge core_clk) disable iff (sys_rst)
      s_reg.uv_f |=> (flags.supply_low_flag && flags.device_fault_summary_flag);
  endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("supply low flag missing");

  property p_ov_flag;
    @(posedge core_clk) disable iff (sys_rst)
      s_reg.ov_f |=> (flags.supply_high_flag && flags.device_fault_summary_flag);
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("supply high flag missing");

  property p_uv_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (flags.supply_low_flag && (uv_s || !dev_status_read)) |=> flags.supply_low_flag;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("supply low cleared early");

  property p_ov_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (flags.supply_high_flag && (ov_s || !dev_status_read)) |=> flags.supply_high_flag;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("supply high cleared early");

  property p_cp_off;
    @(posedge core_clk) disable iff (sys_rst) s_reg.cp_f |=> (power_outputs == 5'h00);
  endproperty
  a_cp_off: assert property (p_cp_off) else $error("outputs on during pump fault");

  property p_cp_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (flags.pump_fault_flag && (cp_s || !quick_status_read)) |=> flags.pump_fault_flag;
  endproperty
  a_cp_hold: assert property (p_cp_hold) else $error("pump flag cleared early");

  property p_glitch;
    @(posedge core_clk) disable iff (sys_rst) !uv_s |=> (s_reg.uv_cnt == 11'h000);
  endproperty
  a_glitch: assert property (p_glitch) else $error("filter not restarted");

  property p_up_off;
    @(posedge core_clk) disable iff (sys_rst)
      (s_reg.st == ST_UP && !settled_s) |=> (power_outputs == 5'h00);
  endproperty
  a_up_off: assert property (p_up_off) else $error("outputs on before pump settled");

  property p_uv_len;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(s_reg.uv_f) |-> (s_reg.uv_cnt == sfsup_pkg::FILT_W'(SUPPLY_FILT_CYC));
  endproperty
  a_uv_len: assert property (p_uv_len) else $error("supply low filter too short");

  property p_ov_len;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(s_reg.ov_f) |-> (s_reg.ov_cnt == sfsup_pkg::FILT_W'(SUPPLY_FILT_CYC));
  endproperty
  a_ov_len: assert property (p_ov_len) else $error("supply high filter too short");

  property p_cp_len;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(s_reg.cp_f) |-> (s_reg.cp_cnt == sfsup_pkg::FILT_W'(PUMP_FILT_CYC));
  endproperty
  a_cp_len: assert property (p_cp_len) else $error("pump filter too short");

  property p_uv_src;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(flags.supply_low_flag) |-> $past(s_reg.uv_f);
  endproperty
  a_uv_src: assert property (p_uv_src) else $error("supply low flag without fault");

  property p_cp_src;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(flags.pump_fault_flag) |-> $past(s_reg.cp_f);
  endproperty
  a_cp_src: assert property (p_cp_src) else $error("pump flag without fault");

  property p_cp_flag;
    @(posedge core_clk) disable iff (sys_rst)
      s_reg.cp_f |=> (flags.pump_fault_flag && flags.device_fault_summary_flag);
  endproperty
  a_cp_flag: assert property (p_cp_flag) else $error("pump flag missing");

  property p_summary;
    @(posedge core_clk) disable iff (sys_rst)
      flags.device_fault_summary_flag ==
        (flags.supply_low_flag || flags.supply_high_flag || flags.pump_fault_flag);
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag mismatch");

  property p_shut_stay;
    @(posedge core_clk) disable iff (sys_rst)
      (s_reg.st == ST_SHUT && !fail_mode && on_write == 5'h00) |=> (s_reg.st == ST_SHUT);
  endproperty
  a_shut_stay: assert property (p_shut_stay) else $error("restart without on command");

  property p_restart_wait;
    @(posedge core_clk) disable iff (sys_rst)
      (s_reg.st == ST_SHUT && fail_mode &&
        s_reg.rs_cnt < sfsup_pkg::RST_W'(RESTART_CYC - 1)) |=> (s_reg.st == ST_SHUT);
  endproperty
  a_restart_wait: assert property (p_restart_wait) else $error("restart too early");

  property p_restart_go;
    @(posedge core_clk) disable iff (sys_rst)
      (s_reg.st == ST_SHUT && fail_mode && !uv_s &&
        s_reg.rs_cnt == sfsup_pkg::RST_W'(RESTART_CYC - 1)) |=> (s_reg.st == ST_UP);
  endproperty
  a_restart_go: assert property (p_restart_go) else $error("auto restart missing");

  property p_up_exec;
    @(posedge core_clk) disable iff (sys_rst)
      (s_reg.st == ST_UP && settled_s && !s_reg.cp_f && !s_reg.uv_f) |=>
        (power_outputs == s_reg.want);
  endproperty
  a_up_exec: assert property (p_up_exec) else $error("held command not executed");

  property p_inrush_start;
    @(posedge core_clk) disable iff (sys_rst)
      (s_reg.st == ST_UP && settled_s && !s_reg.cp_f && !s_reg.uv_f) |=>
        (inrush_current_window == power_outputs);
  endproperty
  a_inrush_start: assert property (p_inrush_start) else $error("inrush window missing");

  property p_inrush_once;
    @(posedge core_clk) disable iff (sys_rst)
      (inrush_current_window != 5'h00) |=>
        ((inrush_current_window & $past(inrush_current_window)) == 5'h00);
  endproperty
  a_inrush_once: assert property (p_inrush_once) else $error("inrush window too long");

  property p_inrush_sub;
    @(posedge core_clk) disable iff (sys_rst)
      (inrush_current_window & ~power_outputs) == 5'h00;
  endproperty
  a_inrush_sub: assert property (p_inrush_sub) else $error("inrush on channel off");

endmodule

// ### logic/sfsup_pkg.sv
// constants and carrier types for the supply fault supervisor
// assumes one 250 MHz core clock and comparator levels from the analog front end
//
// How it works
// - undervoltage lasting the filter time switches all five outputs off together
// - filtered undervoltage sets supply low flag and fault summary flag
// - normal mode: outputs stay off until supply recovers and on bit written
// - supply low flag clears only after recovery followed by device status read
// - fail mode: outputs off by undervoltage restart automatically
// - auto restart interval typically 64 ms, between 48 and 80 ms
// - overvoltage sets supply high flag and fault summary flag
// - supply high flag clears only after recovery followed by device status read
// - outputs kept off until pump settles; pending turn-on executes on settling
// - pump voltage out of range beyond filter time disables all outputs
// - filtered pump fault sets fault summary flag and pump fault flag
// - turn-on held during pump fault executes, with inrush window, on recovery
// - pump fault flag clears only after recovery followed by quick status read
package sfsup_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned NUM_OUT = 5;
  // filter times in ns, worst case maximum, rounded down to whole cycles
  localparam int unsigned SUPPLY_FILT_NS = 5500;
  localparam int unsigned PUMP_FILT_NS = 6000;
  localparam int unsigned SUPPLY_FILT_CYC = SUPPLY_FILT_NS * CLK_MHZ / 1000;
  localparam int unsigned PUMP_FILT_CYC = PUMP_FILT_NS * CLK_MHZ / 1000;
  // restart interval in ms, typical figure
  localparam int unsigned RESTART_MS = 64;
  localparam int unsigned RESTART_CYC = RESTART_MS * CLK_MHZ * 1000;
  localparam int unsigned FILT_W = 11;
  localparam int unsigned RST_W = 25;

  typedef struct packed {
    logic supply_low;
    logic supply_high;
    logic pump_bad;
  } sfsup_cond_t;

  typedef struct packed {
    logic device_fault_summary_flag;
    logic supply_low_flag;
    logic supply_high_flag;
    logic pump_fault_flag;
  } sfsup_flags_t;
endpackage

// ### tb/sfsup_mcu_model.sv
// controller model: register accesses reach the device as one-cycle strobes
// assumes bench requests are one-cycle pulses on core_clk
`timescale 1ns/1ps
module sfsup_mcu_model (
  // clock
  input wire logic core_clk,
  // bench requests
  input wire logic [4:0] on_req,
  input wire logic dev_req,
  input wire logic quick_req,
  // strobes to the device
  output logic [4:0] on_write,
  output logic dev_status_read,
  output logic quick_status_read
);
  // registered, so every access lands one cycle after its request
  always_ff @(posedge core_clk)
  begin
    on_write <= on_req;
    dev_status_read <= dev_req;
    quick_status_read <= quick_req;
  end
endmodule

// ### tb/sfsup_top_tb.sv
// bench for the supply fault supervisor, access sequences with expected values
// assumes short filter and restart counts set at the instance
`timescale 1ns/1ps
module sfsup_top_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  sfsup_pkg::sfsup_cond_t cond_raw = '0;
  logic pump_settled = 1'b0;
  logic fail_mode = 1'b0;
  logic [4:0] on_req = '0;
  logic [4:0] off_write = '0;
  logic dev_req = 1'b0;
  logic quick_req = 1'b0;
  logic [4:0] on_write;
  logic [4:0] power_outputs;
  logic [4:0] inrush_current_window;
  logic dev_status_read;
  logic quick_status_read;
  sfsup_pkg::sfsup_flags_t flags;
  int num_errors = 0;
  int num_checks = 0;
  int inrush_seen = 0;
  ////////////////////////////////////////////////////////////////////////////
  sfsup_mcu_model mcu (.core_clk(core_clk), .on_req(on_req), .dev_req(dev_req),
    .quick_req(quick_req), .on_write(on_write), .dev_status_read(dev_status_read),
    .quick_status_read(quick_status_read));
  sfsup_top #(.RESTART_CYC(200), .SUPPLY_FILT_CYC(8), .PUMP_FILT_CYC(8)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .cond_raw(cond_raw),
    .pump_settled(pump_settled), .fail_mode(fail_mode), .on_write(on_write),
    .off_write(off_write), .dev_status_read(dev_status_read),
    .quick_status_read(quick_status_read), .power_outputs(power_outputs),
    .inrush_current_window(inrush_current_window), .flags(flags));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (inrush_current_window[1] === 1'b1)
      inrush_seen++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait, then compare outputs
  task automatic wait_out(input logic [4:0] exp, input int n);
    for (int i = 0; i < n && power_outputs !== exp; i++)
      tick(1);
    check("power_outputs", power_outputs, exp);
  endtask
  task automatic cmd(input logic [4:0] m, input logic d, input logic q);
    on_req <= m;
    dev_req <= d;
    quick_req <= q;
    tick(1);
    on_req <= '0;
    dev_req <= 1'b0;
    quick_req <= 1'b0;
    tick(4);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(4 * 5000);
    num_errors++;
    complete_run();
  end
  initial
  begin
    tick(5);
    sys_rst <= 1'b0;
    tick(1);
    check("flags", flags, 5'h00);
    cmd(5'h01, 1'b0, 1'b0);
    tick(10);
    check("power_outputs", power_outputs, 5'h00);
    pump_settled <= 1'b1;
    wait_out(5'h01, 10);
    cond_raw <= 3'b100;
    tick(4);
    cond_raw <= '0;
    tick(20);
    check("flags", flags, 5'h00);
    check("power_outputs", power_outputs, 5'h01);
    cond_raw <= 3'b100;
    wait_out(5'h00, 20);
    tick(2);
    check("flags", flags, 5'h0C);
    cmd(5'h00, 1'b1, 1'b0);
    check("flags", flags, 5'h0C);
    cond_raw <= '0;
    tick(10);
    check("power_outputs", power_outputs, 5'h00);
    cmd(5'h00, 1'b1, 1'b0);
    check("flags", flags, 5'h00);
    cmd(5'h1F, 1'b0, 1'b0);
    wait_out(5'h1F, 10);
    cond_raw <= 3'b010;
    tick(20);
    check("flags", flags, 5'h0A);
    cmd(5'h00, 1'b1, 1'b0);
    cond_raw <= '0;
    tick(10);
    check("flags", flags, 5'h0A);
    cmd(5'h00, 1'b1, 1'b0);
    check("flags", flags, 5'h00);
    off_write <= 5'h1F;
    tick(1);
    off_write <= '0;
    cond_raw <= 3'b001;
    tick(20);
    check("flags", flags, 5'h09);
    cmd(5'h02, 1'b0, 1'b1);
    check("power_outputs", power_outputs, 5'h00);
    check("flags", flags, 5'h09);
    inrush_seen = 0;
    cond_raw <= '0;
    wait_out(5'h02, 20);
    tick(2);
    check("inrush", 5'(inrush_seen), 5'h01);
    cmd(5'h00, 1'b0, 1'b1);
    check("flags", flags, 5'h00);
    fail_mode <= 1'b1;
    cond_raw <= 3'b100;
    wait_out(5'h00, 20);
    cond_raw <= '0;
    tick(150);
    check("power_outputs", power_outputs, 5'h00);
    wait_out(5'h02, 80);
    complete_run();
  end
endmodule
